// File: src/tcss_top.v
// major state sequencer and control flags of the tape controller
`timescale 1ns/1ps
`include "tcss_defs.vh"
module tcss_top (
  input wire core_clk,
  input wire resetn,
  // processor side, same clock
  input wire power_clear,
  input wire flag_set_instr,
  input wire io_preset_instr,
  input wire extended_op_load_instr,
  input wire [0:11] acc,
  input wire instruction_setup_pulse,
  input wire second_word_setup_pulse,
  input wire [0:11] second_word,
  input wire [1:0] if_bits,
  input wire [1:0] data_field_bits,
  input wire move_toward_block_instr,
  input wire write_verify_instr,
  input wire write_verify_group_instr,
  input wire write_group_instr,
  input wire read_group_instr,
  input wire write_instr,
  input wire continue_motion,
  input wire group_equal,
  input wire [0:11] tape_accumulator,
  input wire forward,
  input wire timing_fault_window,
  input wire word_ready,
  input wire xfer_ack,
  input wire drive_req,
  input wire done_clear,
  input wire unit_changed,
  // transport pins, foreign timing
  input wire timing_pulse_one,
  input wire timing_pulse_two,
  input wire timing_pulse_three,
  input wire time_state_one,
  input wire block_mark,
  input wire final_mark,
  input wire check_mark,
  input wire unit_valid,
  input wire remote_mode,
  input wire write_enabled,
  // outputs
  output reg idle_state_ff,
  output reg search_state_ff,
  output reg block_state_ff,
  output reg checksum_word_state_ff,
  output reg reverse_stop_state_ff,
  output reg write_sync_ff,
  output reg write_gate_ff,
  output reg write_cycle_ff,
  output reg phase_invert_ff,
  output reg transport_ready_ff,
  output reg [1:0] inst_field_ff,
  output reg [1:0] data_field_ff,
  output reg format_mark_ff,
  output reg int_enable_ff,
  output reg maint_mode_ff,
  output reg extended_addressing_flag_ff,
  output reg no_pause_ff,
  output reg hold_motion_ff,
  output reg [11:0] block_number_ff,
  output reg group_count_en_ff,
  output reg op_active_ff,
  output reg tape_pause_ff,
  output reg xfer_req_ff,
  output reg bus_drive_ff,
  output reg done_ff,
  output reg irq_ff,
  output reg motion_ff
);

  // ==========================================
  // localparams for state codes
  localparam [2:0] ST_IDLE = `TCSS_ST_IDLE;
  localparam [2:0] ST_SEARCH = `TCSS_ST_SEARCH;
  localparam [2:0] ST_BLOCK = `TCSS_ST_BLOCK;
  localparam [2:0] ST_CHKWRD = `TCSS_ST_CHKWRD;
  localparam [2:0] ST_REVSTOP = `TCSS_ST_REVSTOP;

  // ==========================================
  // transport pin synchronisers
  wire [9:0] pin_vec;
  wire [9:0] pin_lvl;
  wire [9:0] pin_rise;

  assign pin_vec = {write_enabled, remote_mode, unit_valid, check_mark, final_mark,
                    block_mark, time_state_one, timing_pulse_three, timing_pulse_two,
                    timing_pulse_one};

  genvar gi;
  generate
    for (gi = 0; gi < 10; gi = gi + 1) begin : g_pin
      tcss_sync_edge u_sync (
        .core_clk(core_clk),
        .resetn(resetn),
        .pin_in(pin_vec[gi]),
        .level_out(pin_lvl[gi]),
        .rise_out(pin_rise[gi])
      );
    end
  endgenerate

  // timing pulses are the edges; marks and states are sampled levels
  wire tp1 = pin_rise[0];
  wire tp2 = pin_rise[1];
  wire tp3 = pin_rise[2];
  wire ts1 = pin_lvl[3];
  wire bm = pin_lvl[4];
  wire fm = pin_lvl[5];
  wire cm = pin_lvl[6];
  wire unit_ok = pin_lvl[7];
  wire remote_ok = pin_lvl[8];
  wire wr_en_ok = pin_lvl[9];

  // ==========================================
  // decoded events; found, chk_end and rev_bm read the major state register
  reg [2:0] state_ff;
  reg [2:0] nxt_state;
  wire tape_preset;
  wire tac_good;
  wire group_op;
  wire unfinished;
  wire found;
  wire chk_end;
  wire rev_bm;

  assign tape_preset = power_clear | (flag_set_instr & acc[`TCSS_AC_FLAG_PRESET])
                     | (io_preset_instr & acc[`TCSS_AC_PRESET]);
  assign tac_good = (tape_accumulator == `TCSS_TAC_ALL_ONES);
  // group work is barred with extended addressing
  assign group_op = (write_group_instr | read_group_instr | write_verify_group_instr)
                  & ~extended_addressing_flag_ff;
  // another pass is needed: failed verify or group not yet done
  assign unfinished = ((write_verify_instr | write_verify_group_instr) & ~tac_good)
                    | (group_op & ~group_equal);
  assign found = (state_ff == ST_SEARCH) & tp2
               & ((tac_good & forward) | (move_toward_block_instr & bm));
  assign chk_end = (state_ff == ST_CHKWRD) & cm & tp1;
  assign rev_bm = (state_ff == ST_REVSTOP) & tp1 & bm;

  // ==========================================
  // major state register
  // forcing conditions take priority over the normal walk
  always @* begin
    nxt_state = state_ff;
    if (tape_preset | instruction_setup_pulse | timing_fault_window) begin
      nxt_state = ST_IDLE;
    end else begin
      case (state_ff)
        ST_IDLE: begin
          if (op_active_ff & tp1) begin
            nxt_state = ST_SEARCH;
          end
        end
        ST_SEARCH: begin
          if (found) begin
            nxt_state = ST_BLOCK;
          end
        end
        ST_BLOCK: begin
          if (fm & tp2) begin
            nxt_state = ST_CHKWRD;
          end
        end
        ST_CHKWRD: begin
          if (op_active_ff & tp1 & unfinished) begin
            nxt_state = ST_IDLE;
          end else if (chk_end) begin
            nxt_state = ST_REVSTOP;
          end
        end
        ST_REVSTOP: begin
          if (tp2 | rev_bm) begin
            nxt_state = ST_IDLE;
          end
        end
        default: begin
          nxt_state = ST_IDLE;
        end
      endcase
    end
  end

  // state code plus one-hot registered copies for the outputs
  always @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      state_ff <= ST_IDLE;
      idle_state_ff <= 1'h1;
      search_state_ff <= 1'h0;
      block_state_ff <= 1'h0;
      checksum_word_state_ff <= 1'h0;
      reverse_stop_state_ff <= 1'h0;
      phase_invert_ff <= 1'h0;
    end else begin
      state_ff <= nxt_state;
      idle_state_ff <= (nxt_state == ST_IDLE);
      search_state_ff <= (nxt_state == ST_SEARCH);
      block_state_ff <= (nxt_state == ST_BLOCK);
      checksum_word_state_ff <= (nxt_state == ST_CHKWRD);
      reverse_stop_state_ff <= (nxt_state == ST_REVSTOP);
      // checksum goes out complemented on writes
      phase_invert_ff <= (nxt_state == ST_CHKWRD) & write_instr;
    end
  end

  // ==========================================
  // write sync, write gate and write cycle
  wire write_clear = cm & ts1;

  always @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      write_sync_ff <= `TCSS_FLAG_RESET;
      write_gate_ff <= `TCSS_FLAG_RESET;
    end else if (write_clear | tape_preset) begin
      write_sync_ff <= 1'h0;
      write_gate_ff <= 1'h0;
    end else begin
      if (state_ff == ST_BLOCK && tp1) begin
        write_sync_ff <= 1'h1;
      end
      // gate held off during the verify pass
      if (write_sync_ff & tp3 & write_cycle_ff & write_instr) begin
        write_gate_ff <= 1'h1;
      end
      if (!write_cycle_ff) begin
        write_gate_ff <= 1'h0;
      end
    end
  end

  // a bad verify re-arms writing so the block is recorded again
  always @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      write_cycle_ff <= `TCSS_FLAG_RESET;
    end else if (instruction_setup_pulse) begin
      write_cycle_ff <= 1'h1;
    end else if (chk_end) begin
      write_cycle_ff <= (write_verify_instr | write_verify_group_instr) & ~tac_good;
    end
  end

  // group count advances only on blocks passed while write cycle is set
  always @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      group_count_en_ff <= 1'h0;
    end else begin
      group_count_en_ff <= chk_end & write_cycle_ff & group_op;
    end
  end

  // ==========================================
  // transport readiness
  always @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      transport_ready_ff <= 1'h0;
    end else begin
      transport_ready_ff <= unit_ok & remote_ok & (~write_instr | wr_en_ok);
    end
  end

  // ==========================================
  // field latches and block number at second setup
  always @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      inst_field_ff <= `TCSS_FIELD_RESET;
      data_field_ff <= `TCSS_FIELD_RESET;
      block_number_ff <= `TCSS_WORD_RESET;
    end else if (second_word_setup_pulse) begin
      inst_field_ff <= if_bits;
      data_field_ff <= data_field_bits;
      if (extended_addressing_flag_ff) begin
        block_number_ff <= {1'h0, second_word[1:11]};
      end else begin
        block_number_ff <= second_word;
      end
    end
  end

  // ==========================================
  // extended operation flags
  always @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      format_mark_ff <= `TCSS_FLAG_RESET;
      int_enable_ff <= `TCSS_FLAG_RESET;
      maint_mode_ff <= `TCSS_FLAG_RESET;
      extended_addressing_flag_ff <= `TCSS_FLAG_RESET;
      no_pause_ff <= `TCSS_FLAG_RESET;
      hold_motion_ff <= `TCSS_FLAG_RESET;
    end else if (extended_op_load_instr) begin
      format_mark_ff <= acc[`TCSS_AC_MARK];
      int_enable_ff <= acc[`TCSS_AC_INT_EN];
      maint_mode_ff <= acc[`TCSS_AC_MAINT];
      extended_addressing_flag_ff <= acc[`TCSS_AC_EXT_ADDR];
      no_pause_ff <= acc[`TCSS_AC_NO_PAUSE];
      hold_motion_ff <= acc[`TCSS_AC_HOLD];
    end
  end

  // ==========================================
  // operation activity, pause and completion
  wire complete = chk_end & ~unfinished;

  always @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      op_active_ff <= 1'h0;
      tape_pause_ff <= 1'h0;
    end else begin
      if (tape_preset | complete) begin
        op_active_ff <= 1'h0;
      end else if (second_word_setup_pulse) begin
        op_active_ff <= 1'h1;
      end
      // processor keeps running when pause is off
      tape_pause_ff <= op_active_ff & ~no_pause_ff;
    end
  end

  // done flag: a new completion beats a clear in the same cycle
  always @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      done_ff <= 1'h0;
      irq_ff <= 1'h0;
    end else begin
      if (complete) begin
        done_ff <= 1'h1;
      end else if (done_clear | tape_preset) begin
        done_ff <= 1'h0;
      end
      irq_ff <= (done_ff | complete) & ~(done_clear & ~complete) & int_enable_ff;
    end
  end

  // ==========================================
  // word transfer request and bus drive
  always @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      xfer_req_ff <= 1'h0;
      bus_drive_ff <= 1'h0;
    end else begin
      if (word_ready & (state_ff == ST_BLOCK)) begin
        xfer_req_ff <= 1'h1;
      end else if (xfer_ack | (state_ff != ST_BLOCK)) begin
        xfer_req_ff <= 1'h0;
      end
      bus_drive_ff <= drive_req & (state_ff == ST_BLOCK);
    end
  end

  // ==========================================
  // motion; stops at the block mark in reverse stop unless continue_motion is set
  always @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      motion_ff <= 1'h0;
    end else if (tape_preset) begin
      motion_ff <= 1'h0;
    end else if (instruction_setup_pulse) begin
      motion_ff <= 1'h1;
    end else if (rev_bm & ~continue_motion) begin
      motion_ff <= 1'h0;
    end else if (unit_changed & ~hold_motion_ff) begin
      motion_ff <= 1'h0;
    end
  end

endmodule

// File: src/tcss_defs.vh
// constants of the tape control state sequencer
`ifndef TCSS_DEFS_VH
`define TCSS_DEFS_VH

// ==========================================
// major state codes
`define TCSS_ST_IDLE 3'h0
`define TCSS_ST_SEARCH 3'h1
`define TCSS_ST_BLOCK 3'h2
`define TCSS_ST_CHKWRD 3'h3
`define TCSS_ST_REVSTOP 3'h4

// ==========================================
// accumulator bit positions, bit 0 most significant
`define TCSS_AC_PRESET 0
`define TCSS_AC_FLAG_PRESET 7
`define TCSS_AC_MARK 4
`define TCSS_AC_INT_EN 5
`define TCSS_AC_MAINT 6
`define TCSS_AC_EXT_ADDR 7
`define TCSS_AC_NO_PAUSE 8
`define TCSS_AC_HOLD 9

// ==========================================
// values
`define TCSS_TAC_ALL_ONES 12'hfff
`define TCSS_FLAG_RESET 1'h0
`define TCSS_FIELD_RESET 2'h0
`define TCSS_WORD_RESET 12'h000

`endif

// File: src/tcss_sync_edge.v
// two-flop synchroniser with rising edge pulse for transport pins
`timescale 1ns/1ps
module tcss_sync_edge (
  core_clk,
  resetn,
  pin_in,
  level_out,
  rise_out
);
  input wire core_clk;
  input wire resetn;
  input wire pin_in;
  output wire level_out;
  output wire rise_out;

  reg meta_ff;
  reg sync_ff;
  reg last_ff;

  // ==========================================
  // synchroniser; first stage feeds only the second
  always @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      meta_ff <= 1'h0;
      sync_ff <= 1'h0;
      last_ff <= 1'h0;
    end else begin
      meta_ff <= pin_in;
      sync_ff <= meta_ff;
      last_ff <= sync_ff;
    end
  end

  assign level_out = sync_ff;
  assign rise_out = sync_ff & ~last_ff; // one cycle per pin pulse
endmodule

// File: bench/tcss_transport.sv
// transport model: timing pulses, marks and switch levels
`timescale 1ns/1ps
module tcss_transport (
  output wire timing_pulse_one,
  output wire timing_pulse_two,
  output wire timing_pulse_three,
  output logic time_state_one,
  output logic block_mark,
  output logic final_mark,
  output logic check_mark,
  output logic unit_valid,
  output logic remote_mode,
  output logic write_enabled
);
  logic [3:1] tp = 3'h0;
  // ==========================================
  // pulse lines, low between events
  assign timing_pulse_one = tp[1];
  assign timing_pulse_two = tp[2];
  assign timing_pulse_three = tp[3];
  // marks idle low, so a stale mark never qualifies a later pulse
  initial begin
    {time_state_one, block_mark, final_mark, check_mark} = 4'h0;
    {unit_valid, remote_mode, write_enabled} = 3'h0;
  end
  // one event per 200 ns link period: marks settle, pulse, release
  task automatic ev(input int n, input logic [2:0] mk);
    {block_mark, final_mark, check_mark} = mk;
    time_state_one = mk[0];
    #50;
    tp[n] = 1'b1;
    #100;
    tp[n] = 1'b0;
    #50;
    {time_state_one, block_mark, final_mark, check_mark} = 4'h0;
  endtask
  // manual switch levels of the selected unit
  task automatic sw(input logic u, input logic r, input logic w);
    {unit_valid, remote_mode, write_enabled} = {u, r, w};
  endtask
endmodule

// File: bench/tcss_top_asserts.sv
// concurrent checks on the ports of the state sequencer
`timescale 1ns/1ps
module tcss_checker (
  input wire core_clk,
  input wire resetn,
  input wire power_clear,
  input wire flag_set_instr,
  input wire io_preset_instr,
  input wire extended_op_load_instr,
  input wire [0:11] acc,
  input wire instruction_setup_pulse,
  input wire second_word_setup_pulse,
  input wire [1:0] if_bits,
  input wire [1:0] data_field_bits,
  input wire timing_fault_window,
  input wire idle_state_ff,
  input wire search_state_ff,
  input wire block_state_ff,
  input wire checksum_word_state_ff,
  input wire reverse_stop_state_ff,
  input wire write_sync_ff,
  input wire write_gate_ff,
  input wire write_cycle_ff,
  input wire [1:0] inst_field_ff,
  input wire [1:0] data_field_ff,
  input wire format_mark_ff,
  input wire int_enable_ff,
  input wire maint_mode_ff,
  input wire extended_addressing_flag_ff,
  input wire no_pause_ff,
  input wire hold_motion_ff,
  input wire xfer_req_ff,
  input wire done_ff,
  input wire irq_ff
);
  default clocking @(posedge core_clk); endclocking
  default disable iff (!resetn);
  // ==========================================
  // major states
  one_hot_state_a: assert property (
    $onehot({idle_state_ff, search_state_ff, block_state_ff, checksum_word_state_ff,
    reverse_stop_state_ff})) else $error("major state not one-hot");
  block_from_search_a: assert property (
    $rose(block_state_ff) |-> $past(search_state_ff)) else $error("block not from search");
  preset_idle_a: assert property (
    power_clear || (flag_set_instr && acc[7]) || (io_preset_instr && acc[0])
    |-> ##[1:2] idle_state_ff) else $error("preset missed idle");
  start_idle_a: assert property (
    instruction_setup_pulse || timing_fault_window |-> ##[1:2] idle_state_ff)
    else $error("start or fault missed idle");
  // ==========================================
  // write flags, transfers and interrupt
  gate_after_sync_a: assert property (
    $rose(write_gate_ff) |-> write_sync_ff && $past(write_sync_ff))
    else $error("gate rose before sync");
  gate_needs_cycle_a: assert property (
    $rose(write_gate_ff) |-> $past(write_cycle_ff)) else $error("gate without write cycle");
  xfer_in_block_a: assert property (
    $rose(xfer_req_ff) |-> $past(block_state_ff)) else $error("request outside block");
  irq_enabled_a: assert property (
    $rose(irq_ff) |-> int_enable_ff && done_ff) else $error("interrupt not allowed");
  // ==========================================
  // latched fields and extended flags
  ext_load_a: assert property (
    extended_op_load_instr |-> ##[1:2] {format_mark_ff, int_enable_ff, maint_mode_ff,
    extended_addressing_flag_ff, no_pause_ff, hold_motion_ff} == acc[4:9])
    else $error("extended flags wrong");
  field_latch_a: assert property (
    second_word_setup_pulse |-> ##[1:2] inst_field_ff == if_bits && data_field_ff ==
    data_field_bits) else $error("field bits not latched");
  cover property ($rose(block_state_ff));
  cover property ($rose(reverse_stop_state_ff));
  cover property ($rose(irq_ff));
endmodule
bind tcss_top tcss_checker chk_i (.*);

// File: bench/tape_control_state_sequencer_bench.sv
// self-checking bench of the tape control state sequencer
`timescale 1ns/1ps
module tape_control_state_sequencer_bench;
  logic core_clk = 0, resetn = 0, power_clear = 0, flag_set_instr = 0, io_preset_instr = 0;
  logic extended_op_load_instr = 0, instruction_setup_pulse = 0, second_word_setup_pulse = 0;
  logic move_toward_block_instr = 0, write_verify_instr = 0, write_verify_group_instr = 0;
  logic write_group_instr = 0, read_group_instr = 0, write_instr = 0, continue_motion = 0;
  logic group_equal = 1, forward = 1, timing_fault_window = 0, word_ready = 0, xfer_ack = 0;
  logic drive_req = 0, done_clear = 0, unit_changed = 0, ext_on = 0;
  logic np_on = 0, hold_on = 0;
  int gc_seen = 0;
  logic [0:11] acc = 12'h000, second_word = 12'h000, tape_accumulator = 12'h000;
  logic [1:0] if_bits = 2'h0, data_field_bits = 2'h0;
  wire timing_pulse_one, timing_pulse_two, timing_pulse_three, time_state_one, block_mark;
  wire final_mark, check_mark, unit_valid, remote_mode, write_enabled;
  wire idle_state_ff, search_state_ff, block_state_ff, checksum_word_state_ff;
  wire reverse_stop_state_ff, write_sync_ff, write_gate_ff, write_cycle_ff, phase_invert_ff;
  wire transport_ready_ff, format_mark_ff, int_enable_ff, maint_mode_ff, no_pause_ff;
  wire extended_addressing_flag_ff, hold_motion_ff, group_count_en_ff, op_active_ff;
  wire tape_pause_ff, xfer_req_ff, bus_drive_ff, done_ff, irq_ff, motion_ff;
  wire [1:0] inst_field_ff, data_field_ff;
  wire [11:0] block_number_ff;
  int fails = 0, check_count = 0;
  logic [15:0] seed = 16'h8d08; // start value 36104
  logic [4:0] st_exp[$];
  logic [4:0] st_seen = 5'h10;
  wire [4:0] st = {idle_state_ff, search_state_ff, block_state_ff, checksum_word_state_ff,
    reverse_stop_state_ff};

  tcss_top uut (.*);
  tcss_transport xport (.*);

  // ==========================================
  // clock and helpers
  initial forever #12.5 core_clk = ~core_clk;
  function automatic logic [15:0] rnd();
    seed ^= seed << 7;
    seed ^= seed >> 9;
    seed ^= seed << 8;
    return seed;
  endfunction
  // inputs always move 2 ns after the rising edge
  task automatic tick(int n = 1);
    repeat (n) @(posedge core_clk);
    #2;
  endtask
  task automatic strobe(ref logic s);
    s = 1'b1;
    tick();
    s = 1'b0;
  endtask
  task automatic chk(logic [11:0] got, logic [11:0] exp);
    check_count++;
    if (got !== exp) begin
      fails++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic complete_run();
    $display("checks %0d fails %0d", check_count, fails);
    if (fails == 0 && check_count > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask
  // one transport event; note the major state it should lead to
  task automatic step(int n, logic [2:0] mk, logic [4:0] nxt);
    if (nxt != 5'h00)
      st_exp.push_back(nxt);
    xport.ev(n, mk);
    tick(4);
  endtask
  task automatic load_flags(logic [15:0] v);
    acc = v[11:0];
    ext_on = v[4];
    np_on = v[3];
    hold_on = v[2];
    strobe(extended_op_load_instr);
    tick();
    chk({format_mark_ff, int_enable_ff, maint_mode_ff, extended_addressing_flag_ff,
      no_pause_ff, hold_motion_ff}, v[7:2]);
  endtask
  // two-word start, then the first pulse one opens search
  task automatic op_start(logic [15:0] r);
    logic [15:0] q;
    q = rnd();
    second_word = r[11:0];
    {if_bits, data_field_bits} = r[15:12];
    {xfer_ack, drive_req, unit_changed, continue_motion} = q[3:0];
    if (ext_on)
      acc = q[15:4];
    strobe(instruction_setup_pulse);
    tick();
    strobe(second_word_setup_pulse);
    tick(2);
    chk(write_cycle_ff, 1);
    chk({inst_field_ff, data_field_ff}, r[15:12]);
    chk(block_number_ff, ext_on ? {1'b0, r[10:0]} : r[11:0]);
    chk({op_active_ff, tape_pause_ff}, {1'b1, !np_on});
    step(1, 3'h0, 5'h08);
  endtask

  // ==========================================
  // state watcher: each change takes the oldest note
  always @(posedge core_clk) begin
    if (resetn && st !== st_seen) begin
      st_seen = st;
      chk(st, st_exp.size() ? st_exp.pop_front() : 5'h1f);
    end
  end

  // group count pulses last one cycle, so they are tallied here
  always @(posedge core_clk) begin
    if (resetn && group_count_en_ff)
      gc_seen++;
  end

  // watchdog at several times the expected run
  initial begin
    repeat (4000) @(posedge core_clk);
    fails++;
    complete_run();
  end

  // ==========================================
  // main sequence
  initial begin
    tick(16);
    resetn = 1;
    tick(2);
    chk(st, 5'h10);
    write_instr = 1;
    for (int i = 3; i >= 0; i--) begin
      xport.sw(i != 3, i != 2, i != 1);
      tick(6);
      chk(transport_ready_ff, i == 0);
    end
    $display("test 1 done");
    // full write with interrupt enabled, ending on pulse two
    load_flags((rnd() | 16'h0040) & 16'hffef);
    tape_accumulator = 12'hfff;
    op_start(rnd());
    forward = 0;
    step(2, 3'h0, 5'h00);
    forward = 1;
    step(2, 3'h0, 5'h04);
    step(1, 3'h0, 5'h00);
    chk({write_sync_ff, write_gate_ff}, 2'h2);
    step(3, 3'h0, 5'h00);
    chk(write_gate_ff, 1);
    strobe(word_ready);
    chk({xfer_req_ff, bus_drive_ff}, {1'b1, drive_req});
    step(2, 3'h2, 5'h02);
    chk(phase_invert_ff, 1);
    step(1, 3'h1, 5'h01);
    chk({write_sync_ff, write_gate_ff, write_cycle_ff}, 3'h0);
    chk({done_ff, irq_ff}, 2'h3);
    step(2, 3'h0, 5'h10);
    chk(bus_drive_ff, 0);
    strobe(done_clear);
    tick();
    chk(done_ff, 0);
    $display("test 2 done");
    // move toward block, interrupt masked, leave on block mark
    load_flags(rnd() & 16'hffaf);
    write_instr = 0;
    move_toward_block_instr = 1;
    tape_accumulator = 12'h000;
    op_start(rnd());
    step(2, 3'h4, 5'h04);
    step(2, 3'h2, 5'h02);
    chk(phase_invert_ff, 0);
    step(1, 3'h1, 5'h01);
    chk({done_ff, irq_ff}, 2'h2);
    step(1, 3'h4, 5'h10);
    chk(motion_ff, continue_motion & (hold_on | !unit_changed));
    move_toward_block_instr = 0;
    strobe(done_clear);
    $display("test 3 done");
    // group write with group unfinished goes back to idle
    write_group_instr = 1;
    group_equal = 0;
    write_instr = 1;
    tape_accumulator = 12'hfff;
    op_start(rnd());
    step(2, 3'h0, 5'h04);
    step(2, 3'h2, 5'h02);
    step(1, 3'h1, 5'h10);
    chk(done_ff, 0);
    chk(gc_seen, 1);
    write_group_instr = 0;
    group_equal = 1;
    // failed verify rewrites the block, good verify completes
    write_verify_instr = 1;
    op_start(rnd());
    step(2, 3'h0, 5'h04);
    step(2, 3'h2, 5'h02);
    tape_accumulator = 12'h7fe;
    step(1, 3'h1, 5'h10);
    chk(write_cycle_ff, 1);
    tape_accumulator = 12'hfff;
    step(1, 3'h0, 5'h08);
    step(2, 3'h0, 5'h04);
    step(2, 3'h2, 5'h02);
    step(1, 3'h1, 5'h01);
    chk({write_cycle_ff, done_ff}, 2'h1);
    step(2, 3'h0, 5'h10);
    write_verify_instr = 0;
    $display("test 4 done");
    // every preset source and the timing fault abort a search
    load_flags(rnd() | 16'h0010);
    for (int k = 0; k < 4; k++) begin
      op_start(rnd());
      st_exp.push_back(5'h10);
      acc = (k == 1) ? 12'h010 : 12'h800;
      case (k)
        0: strobe(power_clear);
        1: strobe(flag_set_instr);
        2: strobe(io_preset_instr);
        default: strobe(timing_fault_window);
      endcase
      tick(2);
    end
    tick(4);
    chk(st_exp.size(), 0);
    $display("test 5 done");
    complete_run();
  end
endmodule
